// ---- rtl/charge_seq_defines.vh ----
// Constants for the charge stage and status indicator sequencer.
`ifndef CHARGE_SEQ_DEFINES_VH
`define CHARGE_SEQ_DEFINES_VH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define CLK_HZ            50000000
`define TICK_US           1000
`define TICK_CYCLES       ((`CLK_HZ / 1000000) * `TICK_US)
`define SHORT_PULSE_MS    10
`define LONG_PULSE_MS     250
`define BURST_PERIOD_MS   3500

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define REG_CTRL          12'h000
`define REG_STATE         12'h004
`define REG_INT_STATUS    12'h008
`define REG_INT_CLEAR     12'h00C
`define REG_INT_ENABLE    12'h010
`define REG_TIMER         12'h014

// ----------------------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------------------
`define CTRL_RUN_BIT      0
`define CTRL_RESET        32'h00000000

// ----------------------------------------------------------------------------
// Stage limit defaults, in milliseconds counted by the stage timer
// ----------------------------------------------------------------------------
`define S12_LIMIT_RESET   32'h00002710
`define S3_LIMIT_RESET    32'h00002710
`define S0_LIMIT_RESET    32'h000009C4

// ----------------------------------------------------------------------------
// Charger states
// ----------------------------------------------------------------------------
`define ST_STAGE0         3'h0
`define ST_STAGE1         3'h1
`define ST_STAGE2         3'h2
`define ST_STAGE3         3'h3
`define ST_DONE           3'h4
`define ST_FAULT          3'h5

// ----------------------------------------------------------------------------
// Fault codes (number of long pulses on the fault output)
// ----------------------------------------------------------------------------
`define FLT_NONE          3'h0
`define FLT_ABSENT        3'h1
`define FLT_TEMP          3'h2
`define FLT_TIMER         3'h3
`define FLT_UNDERV        3'h4

// ----------------------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------------------
`define IRQ_STAGE_BIT     0
`define IRQ_DONE_BIT      1
`define IRQ_FAULT_BIT     2

`endif

// ---- rtl/charge_stage_status_sequencer.v ----
// Charge stage sequencer with status and fault indicator encoding, APB slave.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// (R1) Stage 2 timer expiry: stop, timer fault
// (R2) Timed, no stage 3, low current: done
// (R3) Untimed, stage 3 on: low current enters stage 3
// (R4) Untimed, no stage 3: stage 2 forever
// (R5) Untimed stage 3 holds; sag/overcurrent restarts stage 0
// (R6) Stage 3 timer expiry means done
// (R7) Both config low: narrow range, plain
// (R8) Lead-acid config: wide, stage 3, compensated
// (R9) Status burst repeats every 3.5 seconds
// (R10) Outputs high for on, low off
// (R11) Status output doubles as serial transmit
// (R12) Stage pulse codes on status output
// (R13) Status steady on when done or idle-low
// (R14) Fault: short status pulse, coded fault pulses
// (R15) Stage timers start on stage entry; the code keeps the frozen count when a fault returns to stage 0
// (R16) Temperature fault freezes running timer
// (R17) Equal gaps inside bursts, then low
module charge_stage_status_sequencer (
	// APB
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Decoded configuration
	input  wire        stage3_enable,
	input  wire        temp_comp_enable,
	input  wire        wide_temp_range,
	input  wire        time_limits_enable,
	// Analog comparator results
	input  wire        battery_present,
	input  wire        temp_valid,
	input  wire        battery_undervoltage,
	input  wire        stage1_done,
	input  wire        stage0_done,
	input  wire        current_below_c10,
	input  wire        current_above_c5,
	input  wire        vbat_below_s3_96,
	input  wire        vbat_drop_to_stage1,
	// Serial status
	input  wire        uart_tx_active,
	input  wire        uart_tx_data,
	// Outputs
	output wire        status_out,
	output wire        fault_out,
	output wire        charge_enable,
	output wire        use_stage3_limit,
	output wire        temp_comp_active,
	output wire        irq
);

	`include "charge_seq_defines.vh"

	reg  [31:0] ctrl;
	reg  [2:0]  state;
	reg  [2:0]  next_state;
	reg  [2:0]  fault_code;
	reg  [2:0]  next_fault_code;
	reg  [2:0]  int_status;
	reg  [2:0]  int_enable;
	reg  [31:0] s0_limit;
	reg  [31:0] s12_limit;
	reg  [31:0] s3_limit;
	reg  [31:0] stage_timer;
	reg  [31:0] tick_cnt;
	reg  [11:0] period_cnt;
	reg         ms_tick;
	reg         period_start;
	reg         s0_expired;
	reg         s12_expired;
	reg         s3_expired;
	reg         low_current_hold;
	reg  [2:0]  status_count;
	reg         status_short;
	reg         status_steady;
	reg  [2:0]  fault_count;
	wire        running;
	wire        wr_en;
	wire        rd_en;
	wire        timer_expired;
	wire        stage_event;
	wire        status_led;

	assign running = ctrl[`CTRL_RUN_BIT];
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	// ------------------------------------------------------------------------
	// Time base
	// ------------------------------------------------------------------------
	// A millisecond enable feeds both burst generators; the period counter sets
	// the burst repetition rate. [R9]
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt     <= 32'h00000000;
			ms_tick      <= 1'b0;
			period_cnt   <= 12'h000;
			period_start <= 1'b0;
		end else begin
			ms_tick      <= 1'b0;
			period_start <= 1'b0;
			if (tick_cnt == `TICK_CYCLES - 1) begin
				tick_cnt <= 32'h00000000;
				ms_tick  <= 1'b1;
				if (period_cnt == 12'd`BURST_PERIOD_MS - 12'd1) begin
					period_cnt   <= 12'h000;
					period_start <= running; // [R9]
				end else begin
					period_cnt <= period_cnt + 12'h001;
				end
			end else begin
				tick_cnt <= tick_cnt + 32'h00000001;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Stage timer
	// ------------------------------------------------------------------------
	// One timer serves stage 0, stages 1+2 together, and stage 3. Expiry flags
	// stay set so that re-entering an expired stage also stops charging.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_timer <= 32'h00000000;
			s0_expired  <= 1'b0;
			s12_expired <= 1'b0;
			s3_expired  <= 1'b0;
		end else if (!running || state == `ST_DONE) begin
			stage_timer <= 32'h00000000;
			s0_expired  <= 1'b0;
			s12_expired <= 1'b0;
			s3_expired  <= 1'b0;
		end else if (next_state != state && (next_state == `ST_STAGE0 || next_state == `ST_STAGE1 ||
				next_state == `ST_STAGE3) && state != `ST_FAULT) begin
			stage_timer <= 32'h00000000; // [R15]
		end else if (ms_tick && time_limits_enable && temp_valid && state != `ST_FAULT) begin
			// A temperature fault leaves the count frozen. [R16]
			stage_timer <= stage_timer + 32'h00000001;
			if (state == `ST_STAGE0 && stage_timer >= s0_limit)
				s0_expired <= 1'b1; // [R15]
			if ((state == `ST_STAGE1 || state == `ST_STAGE2) && stage_timer >= s12_limit)
				s12_expired <= 1'b1; // [R15]
			if (state == `ST_STAGE3 && stage_timer >= s3_limit)
				s3_expired <= 1'b1; // [R15]
		end
	end

	assign timer_expired = (state == `ST_STAGE0 && s0_expired) ||
		((state == `ST_STAGE1 || state == `ST_STAGE2) && s12_expired);

	// ------------------------------------------------------------------------
	// Charger state machine
	// ------------------------------------------------------------------------
	// Faults have priority over stage progress; absent battery outranks the
	// temperature check because the thermistor travels with the battery.
	always @* begin
		next_state      = state;
		next_fault_code = fault_code;
		case (state)
			`ST_STAGE0: if (stage0_done) next_state = `ST_STAGE1;
			`ST_STAGE1: if (stage1_done) next_state = `ST_STAGE2;
			`ST_STAGE2: begin
				if (vbat_drop_to_stage1)
					next_state = `ST_STAGE1; // [R4]
				else if (current_below_c10 && stage3_enable)
					next_state = `ST_STAGE3; // [R3]
				else if (current_below_c10 && time_limits_enable)
					next_state = `ST_DONE; // [R2]
			end
			`ST_STAGE3: begin
				if (time_limits_enable && s3_expired)
					next_state = `ST_DONE; // [R6]
				else if (!time_limits_enable && (vbat_below_s3_96 || current_above_c5))
					next_state = `ST_STAGE0; // [R5]
			end
			`ST_DONE:  next_state = `ST_DONE;
			`ST_FAULT: begin
				if ((fault_code == `FLT_ABSENT && battery_present) ||
						(fault_code == `FLT_TEMP && temp_valid) ||
						(fault_code == `FLT_UNDERV && !battery_undervoltage))
					next_state = `ST_STAGE0;
			end
			default:   next_state = `ST_STAGE0;
		endcase
		if (state != `ST_DONE && !(state == `ST_FAULT && fault_code == `FLT_TIMER)) begin
			if (!battery_present) begin
				next_state      = `ST_FAULT;
				next_fault_code = `FLT_ABSENT;
			end else if (!temp_valid) begin
				next_state      = `ST_FAULT;
				next_fault_code = `FLT_TEMP;
			end else if (timer_expired) begin
				next_state      = `ST_FAULT; // [R1]
				next_fault_code = `FLT_TIMER; // [R15]
			end else if (battery_undervoltage) begin
				next_state      = `ST_FAULT;
				next_fault_code = `FLT_UNDERV;
			end
		end
		if (next_state != `ST_FAULT)
			next_fault_code = `FLT_NONE;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state      <= `ST_STAGE0;
			fault_code <= `FLT_NONE;
		end else if (!running) begin
			state      <= `ST_STAGE0;
			fault_code <= `FLT_NONE;
		end else begin
			state      <= next_state;
			fault_code <= next_fault_code;
		end
	end

	// Charging halts in done and every fault state.
	assign charge_enable    = running && state != `ST_DONE && state != `ST_FAULT; // [R1]
	assign use_stage3_limit = state == `ST_STAGE3;
	// Configuration straps (both low, or lead-acid) arrive decoded. [R7] [R8]
	assign temp_comp_active = temp_comp_enable;

	// ------------------------------------------------------------------------
	// Indicator patterns
	// ------------------------------------------------------------------------
	// Untimed stage 2 with no stage 3 keeps status on below C/10 until the
	// current rises past C/5 again.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			low_current_hold <= 1'b0;
		else if (state != `ST_STAGE2 || stage3_enable || time_limits_enable || current_above_c5)
			low_current_hold <= 1'b0;
		else if (current_below_c10)
			low_current_hold <= 1'b1; // [R13]
	end

	always @* begin
		status_count  = 3'h1;
		status_short  = 1'b0;
		status_steady = 1'b0;
		fault_count   = 3'h0;
		case (state)
			`ST_STAGE0: status_short = 1'b1; // [R12]
			`ST_STAGE1: status_count = 3'h1; // [R12]
			`ST_STAGE2: begin
				status_count  = 3'h2; // [R12]
				status_steady = low_current_hold; // [R13]
			end
			`ST_STAGE3: status_count = 3'h3; // [R12]
			`ST_DONE:   status_steady = 1'b1; // [R13]
			`ST_FAULT: begin
				status_short = 1'b1; // [R14]
				fault_count  = fault_code; // [R14]
			end
			default:    status_count = 3'h1;
		endcase
	end

	pulse_burst u_status_burst (
		.pclk         (pclk),
		.presetn      (presetn),
		.ms_tick      (ms_tick),
		.period_start (period_start),
		.pulse_count  (running ? status_count : 3'h0),
		.short_pulse  (status_short),
		.steady_on    (running && status_steady),
		.led_out      (status_led)
	);

	pulse_burst u_fault_burst (
		.pclk         (pclk),
		.presetn      (presetn),
		.ms_tick      (ms_tick),
		.period_start (period_start),
		.pulse_count  (running ? fault_count : 3'h0),
		.short_pulse  (1'b0),
		.steady_on    (1'b0),
		.led_out      (fault_out) // [R14] [R10]
	);

	// The serial transmitter borrows the status line while it sends. [R11]
	assign status_out = uart_tx_active ? uart_tx_data : status_led; // [R10]

	// ------------------------------------------------------------------------
	// Interrupts and registers
	// ------------------------------------------------------------------------
	assign stage_event = next_state != state && running;
	assign irq         = |(int_status & int_enable);

	// Hardware set wins over a simultaneous software clear.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl       <= `CTRL_RESET;
			int_status <= 3'h0;
			int_enable <= 3'h0;
			s0_limit   <= `S0_LIMIT_RESET;
			s12_limit  <= `S12_LIMIT_RESET;
			s3_limit   <= `S3_LIMIT_RESET;
		end else begin
			if (wr_en && paddr == `REG_INT_CLEAR)
				int_status <= int_status & ~pwdata[2:0] | {next_state == `ST_FAULT && stage_event,
					next_state == `ST_DONE && stage_event, stage_event};
			else
				int_status <= int_status | {next_state == `ST_FAULT && stage_event,
					next_state == `ST_DONE && stage_event, stage_event};
			if (wr_en && paddr == `REG_CTRL)
				ctrl <= {31'h00000000, pwdata[`CTRL_RUN_BIT]};
			if (wr_en && paddr == `REG_INT_ENABLE)
				int_enable <= pwdata[2:0];
			if (wr_en && paddr == `REG_TIMER)
				s12_limit <= pwdata;
			if (wr_en && paddr == `REG_TIMER) begin
				s0_limit <= {2'b00, pwdata[31:2]};
				s3_limit <= pwdata;
			end
		end
	end

	always @* begin
		prdata = 32'h00000000;
		if (rd_en) begin
			case (paddr)
				`REG_CTRL:       prdata = ctrl;
				`REG_STATE:      prdata = {20'h00000, wide_temp_range, stage3_enable, time_limits_enable,
					temp_comp_enable, fault_code, state, status_out, fault_out};
				`REG_INT_STATUS: prdata = {29'h00000000, int_status};
				`REG_INT_ENABLE: prdata = {29'h00000000, int_enable};
				`REG_TIMER:      prdata = s12_limit;
				default:         prdata = 32'h00000000;
			endcase
		end
	end

endmodule // charge_stage_status_sequencer

// ---- rtl/pulse_burst.v ----
// Pulse burst generator for one indicator output.
`timescale 1ns/1ps

module pulse_burst (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// Timing
	input  wire        ms_tick,
	input  wire        period_start,
	// Pattern
	input  wire [2:0]  pulse_count,
	input  wire        short_pulse,
	input  wire        steady_on,
	// Output
	output reg         led_out
);

	`include "charge_seq_defines.vh"

	reg  [8:0] ms_cnt;
	reg  [3:0] phase;
	reg  [3:0] phase_limit;
	reg  [2:0] cur_count;
	reg        cur_short;
	wire [8:0] width;

	// Pulse width and gap width are equal inside a burst.
	assign width = cur_short ? 9'd`SHORT_PULSE_MS : 9'd`LONG_PULSE_MS;

	// ------------------------------------------------------------------------
	// Burst sequencing
	// ------------------------------------------------------------------------
	// Pattern is latched at the period start so a stage change mid-burst cannot
	// produce a mixed burst; only steady on cuts a running burst short.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt      <= 9'h000;
			phase       <= 4'h0;
			phase_limit <= 4'h0;
			cur_count   <= 3'h0;
			cur_short   <= 1'b0;
			led_out     <= 1'b0;
		end else if (steady_on) begin
			led_out     <= 1'b1;
			phase_limit <= 4'h0;
		end else if (period_start) begin
			cur_count   <= pulse_count;
			cur_short   <= short_pulse;
			phase       <= 4'h0;
			ms_cnt      <= 9'h000;
			phase_limit <= {pulse_count, 1'b0};
			led_out     <= (pulse_count != 3'h0);
		end else if (ms_tick && (phase < phase_limit)) begin
			if (ms_cnt + 9'h001 >= width) begin
				ms_cnt  <= 9'h000;
				phase   <= phase + 4'h1;
				// Even phases are high, odd phases are the low gap. [R17]
				led_out <= ((phase + 4'h1) < phase_limit) && phase[0];
			end else begin
				ms_cnt  <= ms_cnt + 9'h001;
			end
		end else if (phase >= phase_limit) begin
			led_out <= 1'b0; // [R17]
		end
	end

endmodule // pulse_burst

// ---- tb/charge_seq_sva.sv ----
// Port-level assertions for the charge stage sequencer.
`timescale 1ns/1ps

module charge_seq_sva (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Bus activity
	input wire psel,
	input wire pwrite,
	// Conditions
	input wire temp_comp_enable,
	input wire time_limits_enable,
	input wire battery_present,
	input wire temp_valid,
	input wire battery_undervoltage,
	input wire current_above_c5,
	input wire vbat_below_s3_96,
	input wire uart_tx_active,
	input wire uart_tx_data,
	// Watched outputs
	input wire status_out,
	input wire charge_enable,
	input wire use_stage3_limit,
	input wire temp_comp_active
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// --------------------------------------------------------------
	// Stage 3 sequences
	// --------------------------------------------------------------
	// Untimed stage 3, where the restart conditions apply.
	sequence s_s3_untimed;
		use_stage3_limit && !time_limits_enable;
	endsequence
	// Nothing asks untimed stage 3 to end; bus writes are excluded since run may drop.
	sequence s_s3_quiet;
		s_s3_untimed ##0 (!vbat_below_s3_96 && !current_above_c5 && battery_present
			&& temp_valid && !battery_undervoltage && !(psel && pwrite));
	endsequence

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	chk_serial_pass: assert property (uart_tx_active |-> status_out == uart_tx_data)
		else $error("status output does not follow serial data");
	chk_comp_follow: assert property ($changed(temp_comp_enable) |-> temp_comp_active == temp_comp_enable)
		else $error("compensation output does not follow its setting");
	chk_absent_halts: assert property (!battery_present |=> !charge_enable)
		else $error("charging continues without a battery");
	chk_temp_halts: assert property (!temp_valid |=> !charge_enable)
		else $error("charging continues at invalid temperature");
	chk_underv_halts: assert property (battery_undervoltage |=> !charge_enable)
		else $error("charging continues on undervoltage");
	chk_s3_sag: assert property (s_s3_untimed ##0 vbat_below_s3_96 |=> !use_stage3_limit)
		else $error("stage 3 kept after voltage sag");
	chk_s3_overcur: assert property (s_s3_untimed ##0 current_above_c5 |=> !use_stage3_limit)
		else $error("stage 3 kept after overcurrent");
	chk_s3_hold: assert property (s_s3_quiet |=> use_stage3_limit)
		else $error("untimed stage 3 left without cause");
	chk_s3_charging: assert property (use_stage3_limit |-> charge_enable)
		else $error("stage 3 without charging");
endmodule // charge_seq_sva

bind charge_stage_status_sequencer charge_seq_sva u_sva (.pclk, .presetn, .psel, .pwrite, .temp_comp_enable,
	.time_limits_enable, .battery_present, .temp_valid, .battery_undervoltage, .current_above_c5,
	.vbat_below_s3_96, .uart_tx_active, .uart_tx_data, .status_out, .charge_enable, .use_stage3_limit,
	.temp_comp_active);

// ---- tb/charge_stage_status_sequencer_bench.sv ----
// Self-checking bench for the charge stage sequencer.
`timescale 1ns/1ps
`include "charge_seq_defines.vh"

module charge_stage_status_sequencer_bench;
	logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, rd_smp, r, seed = 32'h000008D9;
	logic        pready, pslverr, status_out, fault_out, charge_enable, use_stage3_limit, temp_comp_active, irq;
	logic        stage3_enable = 1'h0, temp_comp_enable = 1'h0, wide_temp_range = 1'h0, time_limits_enable = 1'h0;
	logic        battery_present = 1'h1, temp_valid = 1'h1, battery_undervoltage = 1'h0, stage1_done = 1'h0;
	logic        stage0_done = 1'h0, current_below_c10 = 1'h0, current_above_c5 = 1'h0, vbat_below_s3_96 = 1'h0;
	logic        vbat_drop_to_stage1 = 1'h0, uart_tx_active = 1'h0, uart_tx_data = 1'h0, status_lit, fault_lit;
	int          err_total = 0, checked = 0, status_flashes, n0, i;

	charge_stage_status_sequencer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .stage3_enable, .temp_comp_enable, .wide_temp_range, .time_limits_enable,
		.battery_present, .temp_valid, .battery_undervoltage, .stage1_done, .stage0_done, .current_below_c10,
		.current_above_c5, .vbat_below_s3_96, .vbat_drop_to_stage1, .uart_tx_active, .uart_tx_data, .status_out,
		.fault_out, .charge_enable, .use_stage3_limit, .temp_comp_active, .irq);
	led_panel u_panel (.pclk, .status_out, .fault_out, .status_lit, .fault_lit, .status_flashes);

	// Clock, and read data captured at the very edge that takes it.
	always #10 pclk = ~pclk;
	always @(posedge pclk) rd_smp <= prdata;

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected fault code and state fields of the state register.
	function automatic logic [5:0] fields(input logic [2:0] st, input logic [2:0] code);
		return {code, st};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One APB transfer; the request stands until pready is seen high.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 100);
		if (pready !== 1'h1)
			err_total++;
		psel <= 1'h0;
		penable <= 1'h0;
		#1 r = rd_smp;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge pclk);
		#1;
	endtask
	task automatic rd_state(input logic [2:0] st, input logic [2:0] code);
		apb(1'h0, `REG_STATE, 32'h0);
		chk(r[7:2], fields(st, code));
	endtask
	// Walk from stage 0 to stage 2; a state follows its condition by one edge.
	task automatic to_stage2();
		@(posedge pclk) stage0_done <= 1'h1;
		@(posedge pclk) stage0_done <= 1'h0;
		stage1_done <= 1'h1;
		@(posedge pclk) stage1_done <= 1'h0;
		tick(1);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Watchdog sized well past the timer expiry wait.
	initial begin
		#1400000;
		err_total++;
		tally_and_finish();
	end

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		tick(16);
		@(posedge pclk) presetn <= 1'h1;
		apb(1'h0, `REG_CTRL, 32'h0);
		chk(r, `CTRL_RESET);
		apb(1'h0, `REG_TIMER, 32'h0);
		chk(r, `S12_LIMIT_RESET);
		apb(1'h0, 12'h100, 32'h0);
		chk(r, 32'h0);
		apb(1'h0, `REG_STATE, 32'h0);
		chk(r[11:8], 4'h0);
		chk(temp_comp_active, 1'h0);
		@(posedge pclk) stage3_enable <= 1'h1;
		temp_comp_enable <= 1'h1;
		wide_temp_range <= 1'h1;
		apb(1'h0, `REG_STATE, 32'h0);
		chk(r[11:8], 4'hD);
		// Stage change interrupt: raise, clear, mask, unmask.
		apb(1'h1, `REG_INT_ENABLE, 32'h1);
		apb(1'h1, `REG_CTRL, 32'h1);
		@(posedge pclk) stage0_done <= 1'h1;
		tick(2);
		chk(irq, 1'h1);
		rd_state(`ST_STAGE1, `FLT_NONE);
		stage0_done <= 1'h0;
		apb(1'h1, `REG_INT_CLEAR, 32'h1);
		chk(irq, 1'h0);
		apb(1'h1, `REG_INT_ENABLE, 32'h0);
		@(posedge pclk) stage1_done <= 1'h1;
		tick(2);
		stage1_done <= 1'h0;
		chk(irq, 1'h0);
		apb(1'h1, `REG_INT_ENABLE, 32'h1);
		chk(irq, 1'h1);
		apb(1'h1, `REG_INT_CLEAR, 32'h1);
		// Untimed stage 3 entry, hold, sag and overcurrent exits.
		@(posedge pclk) current_below_c10 <= 1'h1;
		tick(20);
		chk(use_stage3_limit, 1'h1);
		current_below_c10 <= 1'h0;
		vbat_below_s3_96 <= 1'h1;
		tick(2);
		rd_state(`ST_STAGE0, `FLT_NONE);
		vbat_below_s3_96 <= 1'h0;
		to_stage2();
		current_below_c10 <= 1'h1;
		tick(2);
		current_below_c10 <= 1'h0;
		current_above_c5 <= 1'h1;
		tick(2);
		chk(use_stage3_limit, 1'h0);
		current_above_c5 <= 1'h0;
		// Untimed stage 2 without stage 3 never ends; low current shows steady on.
		stage3_enable <= 1'h0;
		to_stage2();
		current_below_c10 <= 1'h1;
		tick(3);
		chk(status_out, 1'h1);
		n0 = status_flashes;
		tick(100);
		chk(status_flashes, n0);
		rd_state(`ST_STAGE2, `FLT_NONE);
		current_below_c10 <= 1'h0;
		current_above_c5 <= 1'h1;
		tick(3);
		rd_state(`ST_STAGE2, `FLT_NONE);
		chk(status_out, 1'h0);
		current_above_c5 <= 1'h0;
		vbat_drop_to_stage1 <= 1'h1;
		tick(2);
		rd_state(`ST_STAGE1, `FLT_NONE);
		vbat_drop_to_stage1 <= 1'h0;
		stage1_done <= 1'h1;
		tick(2);
		stage1_done <= 1'h0;
		// Timed, no stage 3: low current ends charging as done.
		time_limits_enable <= 1'h1;
		current_below_c10 <= 1'h1;
		tick(2);
		rd_state(`ST_DONE, `FLT_NONE);
		chk(charge_enable, 1'h0);
		chk(status_lit, 1'h1);
		apb(1'h0, `REG_INT_STATUS, 32'h0);
		chk(r[`IRQ_DONE_BIT], 1'h1);
		// Random serial bits pass straight to the status output.
		for (i = 0; i < 8; i++) begin
			@(posedge pclk);
			r = xs();
			uart_tx_data <= r[4];
			uart_tx_active <= 1'h1;
			#1 chk(status_out, uart_tx_data);
		end
		@(posedge pclk) uart_tx_active <= 1'h0;
		current_below_c10 <= 1'h0;
		time_limits_enable <= 1'h0;
		// Stage 2 timer expiry is a timer fault.
		apb(1'h1, `REG_CTRL, 32'h0);
		apb(1'h1, `REG_CTRL, 32'h1);
		to_stage2();
		apb(1'h1, `REG_TIMER, 32'h0);
		@(posedge pclk) time_limits_enable <= 1'h1;
		n0 = 0;
		while (charge_enable === 1'h1 && n0 < 60000) begin
			tick(1);
			n0++;
		end
		if (n0 >= 60000)
			err_total++;
		rd_state(`ST_FAULT, `FLT_TIMER);
		time_limits_enable <= 1'h0;
		apb(1'h1, `REG_TIMER, `S12_LIMIT_RESET);
		apb(1'h1, `REG_CTRL, 32'h0);
		apb(1'h1, `REG_CTRL, 32'h1);
		// Absent, temperature and undervoltage faults, each cleared back to stage 0.
		for (i = 1; i < 4; i++) begin
			to_stage2();
			battery_present <= (i != 1);
			temp_valid <= (i != 2);
			battery_undervoltage <= (i == 3);
			tick(2);
			rd_state(`ST_FAULT, (i == 3) ? `FLT_UNDERV : 3'(i));
			chk(charge_enable, 1'h0);
			battery_present <= 1'h1;
			temp_valid <= 1'h1;
			battery_undervoltage <= 1'h0;
			tick(2);
			rd_state(`ST_STAGE0, `FLT_NONE);
		end
		tally_and_finish();
	end
endmodule // charge_stage_status_sequencer_bench

// ---- tb/led_panel.sv ----
// Indicator lamp model showing what a viewer or status reader sees.
`timescale 1ns/1ps

module led_panel (
	// Clock
	input  wire  pclk,
	// Indicator pins
	input  wire  status_out,
	input  wire  fault_out,
	// What is seen
	output logic status_lit,
	output logic fault_lit,
	output int   status_flashes
);
	logic last_lit = 1'h0;

	// A lamp glows only while its pin is driven high; an unknown level is dark.
	assign status_lit = (status_out === 1'h1);
	assign fault_lit  = (fault_out === 1'h1);

	// Count flashes as a reader would, one per rising level.
	initial status_flashes = 0;
	always @(posedge pclk) begin
		if (status_lit && !last_lit)
			status_flashes <= status_flashes + 1;
		last_lit <= status_lit;
	end
endmodule // led_panel
